// >>> inc/wuns_pkg.sv
// package of the watch-unit nmi enable block: register map, field layout, reset values
// assumes a 32-bit apb register bus with byte addresses and 12 watch events
`default_nettype none

package wuns_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ADDR_W      = 12;
    localparam int DATA_W      = 32;
    localparam int EVENT_COUNT = 12;
    localparam int CAUSE_W     = 4;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS    = 12'h300;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK        = 12'h304;
    localparam logic [ADDR_W-1:0] OFS_NMI_CAUSE       = 12'h308;
    localparam logic [ADDR_W-1:0] OFS_NMI_ENABLE_SET  = 12'h324;
    localparam logic [ADDR_W-1:0] OFS_NMI_ENABLE_CLR  = 12'h328;

    // ------------------------------------------------------------
    // field positions, index order A..L
    // ------------------------------------------------------------
    localparam int POS_AREA_ZERO_WRITE_WATCH        = 0;
    localparam int POS_AREA_ZERO_READ_WATCH         = 1;
    localparam int POS_AREA_ONE_WRITE_WATCH         = 2;
    localparam int POS_AREA_ONE_READ_WATCH          = 3;
    localparam int POS_AREA_TWO_WRITE_WATCH         = 4;
    localparam int POS_AREA_TWO_READ_WATCH          = 5;
    localparam int POS_AREA_THREE_WRITE_WATCH       = 6;
    localparam int POS_AREA_THREE_READ_WATCH        = 7;
    localparam int POS_PERIPH_AREA_ZERO_WRITE_WATCH = 24;
    localparam int POS_PERIPH_AREA_ZERO_READ_WATCH  = 25;
    localparam int POS_PERIPH_AREA_ONE_WRITE_WATCH  = 26;
    localparam int POS_PERIPH_AREA_ONE_READ_WATCH   = 27;

    localparam int FIELD_POS [EVENT_COUNT] = '{
        POS_AREA_ZERO_WRITE_WATCH,  POS_AREA_ZERO_READ_WATCH,
        POS_AREA_ONE_WRITE_WATCH,   POS_AREA_ONE_READ_WATCH,
        POS_AREA_TWO_WRITE_WATCH,   POS_AREA_TWO_READ_WATCH,
        POS_AREA_THREE_WRITE_WATCH, POS_AREA_THREE_READ_WATCH,
        POS_PERIPH_AREA_ZERO_WRITE_WATCH, POS_PERIPH_AREA_ZERO_READ_WATCH,
        POS_PERIPH_AREA_ONE_WRITE_WATCH,  POS_PERIPH_AREA_ONE_READ_WATCH
    };

    // nmi cause word: valid flag on top, index in the low bits
    localparam int POS_CAUSE_VALID = 31;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [EVENT_COUNT-1:0] RST_NMI_ENABLE   = 12'h000;
    localparam logic [EVENT_COUNT-1:0] RST_EVENT_STATUS = 12'h000;
    localparam logic [EVENT_COUNT-1:0] RST_IRQ_MASK     = 12'h000;
    localparam logic [DATA_W-1:0]      RST_PRDATA       = 32'h0000_0000;

endpackage : wuns_pkg

`default_nettype wire

// >>> logic/wuns_w1_bank.sv
// bank of sticky bits with independent set and clear vectors
// assumes set and clear are single-cycle strobes on pclk
`timescale 1ns/1ns
`default_nettype none

module wuns_w1_bank #(
    parameter int                 WIDTH     = 12,
    parameter logic [WIDTH-1:0]   RST_VALUE = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clear_vec,
    output var  logic [WIDTH-1:0] state
);

    // ------------------------------------------------------------
    // one flop per bit
    // ------------------------------------------------------------
    logic [WIDTH-1:0] next_state;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // a set arriving with a clear wins, so no event is lost
            assign next_state[i] = set_vec[i] | (state[i] & ~clear_vec[i]);
        end
    endgenerate

    // one process owns the whole vector, so no bit has two drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RST_VALUE;
        end else begin
            state <= next_state;
        end
    end

endmodule : wuns_w1_bank

`default_nettype wire

// >>> logic/wuns_apb_front.sv
// apb slave handshake: one wait-free access phase, registered answer
// assumes read data and decode hit are combinational from paddr on pclk
`timescale 1ns/1ns
`default_nettype none

module wuns_apb_front (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic        addr_hit,
    input  wire logic        addr_writable,
    input  wire logic [31:0] read_word,
    output var  logic        write_en,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr
);

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    logic setup_phase;
    logic bad_access;

    assign setup_phase = psel & ~penable;
    assign bad_access  = ~addr_hit | (pwrite & ~addr_writable);
    // write lands only on the edge where the master sees pready
    assign write_en    = psel & penable & pready & pwrite & ~pslverr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= wuns_pkg::RST_PRDATA;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & bad_access;
            // read data sampled in setup; stable through the access phase
            if (setup_phase) begin
                prdata <= (pwrite | bad_access) ? wuns_pkg::RST_PRDATA : read_word;
            end
        end
    end

endmodule : wuns_apb_front

`default_nettype wire

// >>> logic/wuns_nmi_enable.sv
// watch-unit nmi enable block: set/clear enable registers, event status, irq and nmi outputs
// assumes watch_event pulses come from logic on pclk; apb master on the same clock
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - write one sets area write-watch nmi enable
// - write one sets area read-watch nmi enable
// - write one sets periph write-watch nmi enable
// - write one sets periph read-watch nmi enable
// - clear register write one clears enable
module wuns_nmi_enable #(
    parameter int EVENTS = wuns_pkg::EVENT_COUNT
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [wuns_pkg::ADDR_W-1:0] paddr,
    input  wire logic [wuns_pkg::DATA_W-1:0] pwdata,
    output var  logic [wuns_pkg::DATA_W-1:0] prdata,
    output var  logic                        pready,
    output var  logic                        pslverr,
    input  wire logic [EVENTS-1:0]           watch_event,
    output var  logic [EVENTS-1:0]           nmi_enable,
    output var  logic                        nmi,
    output var  logic                        irq
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic sel_status;
    logic sel_mask;
    logic sel_cause;
    logic sel_set;
    logic sel_clear;
    logic addr_hit;
    logic addr_writable;
    logic write_en;

    assign sel_status    = (paddr == wuns_pkg::OFS_EVENT_STATUS);
    assign sel_mask      = (paddr == wuns_pkg::OFS_IRQ_MASK);
    assign sel_cause     = (paddr == wuns_pkg::OFS_NMI_CAUSE);
    assign sel_set       = (paddr == wuns_pkg::OFS_NMI_ENABLE_SET);
    assign sel_clear     = (paddr == wuns_pkg::OFS_NMI_ENABLE_CLR);
    assign addr_hit      = sel_status | sel_mask | sel_cause | sel_set | sel_clear;
    // cause is read-only; writing it answers with an error
    assign addr_writable = addr_hit & ~sel_cause;

    // ------------------------------------------------------------
    // field unpack / pack
    // ------------------------------------------------------------
    logic [EVENTS-1:0]           wr_fields;
    logic [EVENTS-1:0]           event_status;
    logic [EVENTS-1:0]           irq_mask;
    logic [EVENTS-1:0]           nmi_pending;
    logic [wuns_pkg::DATA_W-1:0] enable_word;
    logic [wuns_pkg::DATA_W-1:0] status_word;
    logic [wuns_pkg::DATA_W-1:0] mask_word;

    genvar i;
    generate
        for (i = 0; i < EVENTS; i++) begin : g_field
            assign wr_fields[i] = pwdata[wuns_pkg::FIELD_POS[i]];
        end
    endgenerate

    always_comb begin
        enable_word = '0;
        status_word = '0;
        mask_word   = '0;
        for (int k = 0; k < EVENTS; k++) begin
            enable_word[wuns_pkg::FIELD_POS[k]] = nmi_enable[k];
            status_word[wuns_pkg::FIELD_POS[k]] = event_status[k];
            mask_word[wuns_pkg::FIELD_POS[k]]   = irq_mask[k];
        end
    end

    // ------------------------------------------------------------
    // nmi enable: set and clear views of one bank
    // ------------------------------------------------------------
    logic [EVENTS-1:0] enable_set;
    logic [EVENTS-1:0] enable_clear;
    logic              wr_set;
    logic              wr_clear;

    assign wr_set   = write_en & sel_set;
    assign wr_clear = write_en & sel_clear;

    // only ones act; zero bits keep their enable
    generate
        for (i = 0; i < EVENTS; i++) begin : g_enable
            if (i < 8 && (i % 2) == 0) begin : g_area_wr
                assign enable_set[i] = wr_set & wr_fields[i];
            end else if (i < 8) begin : g_area_rd
                assign enable_set[i] = wr_set & wr_fields[i];
            end else if ((i % 2) == 0) begin : g_periph_wr
                assign enable_set[i] = wr_set & wr_fields[i];
            end else begin : g_periph_rd
                assign enable_set[i] = wr_set & wr_fields[i];
            end
            assign enable_clear[i] = wr_clear & wr_fields[i];
        end
    endgenerate

    wuns_w1_bank #(
        .WIDTH     (EVENTS),
        .RST_VALUE (wuns_pkg::RST_NMI_ENABLE)
    ) u_enable (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_vec   (enable_set),
        .clear_vec (enable_clear),
        .state     (nmi_enable)
    );

    // ------------------------------------------------------------
    // event status (sticky, write one to clear) and irq mask
    // ------------------------------------------------------------
    logic [EVENTS-1:0] status_clear;

    assign status_clear = (write_en & sel_status) ? wr_fields : '0;

    wuns_w1_bank #(
        .WIDTH     (EVENTS),
        .RST_VALUE (wuns_pkg::RST_EVENT_STATUS)
    ) u_status (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_vec   (watch_event),
        .clear_vec (status_clear),
        .state     (event_status)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= wuns_pkg::RST_IRQ_MASK;
        end else if (write_en && sel_mask) begin
            irq_mask <= wr_fields;
        end
    end

    // ------------------------------------------------------------
    // cause: lowest pending event routed to nmi
    // ------------------------------------------------------------
    logic [wuns_pkg::CAUSE_W-1:0] cause_index;
    logic [wuns_pkg::DATA_W-1:0]  cause_word;

    assign nmi_pending = event_status & nmi_enable;

    always_comb begin
        cause_index = '0;
        for (int k = EVENTS - 1; k >= 0; k--) begin
            if (nmi_pending[k]) begin
                cause_index = k[wuns_pkg::CAUSE_W-1:0];
            end
        end
    end

    always_comb begin
        cause_word = '0;
        cause_word[wuns_pkg::CAUSE_W-1:0]   = cause_index;
        cause_word[wuns_pkg::POS_CAUSE_VALID] = |nmi_pending;
    end

    // ------------------------------------------------------------
    // read mux and bus handshake
    // ------------------------------------------------------------
    logic [wuns_pkg::DATA_W-1:0] read_word;

    // set and clear both read back the live enables
    assign read_word = ((sel_set | sel_clear) ? enable_word : '0)
                     | (sel_status ? status_word : '0)
                     | (sel_mask   ? mask_word   : '0)
                     | (sel_cause  ? cause_word  : '0);

    wuns_apb_front u_front (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .addr_hit      (addr_hit),
        .addr_writable (addr_writable),
        .read_word     (read_word),
        .write_en      (write_en),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // one cycle late, but glitch-free toward the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi <= 1'b0;
            irq <= 1'b0;
        end else begin
            nmi <= |nmi_pending;
            irq <= |(event_status & irq_mask);
        end
    end

endmodule : wuns_nmi_enable

`default_nettype wire

// >>> bench/wuns_nmi_enable_chk.sv
// checker of the nmi enable block: set/clear writes and readback of the enables
// assumes it is bound into the top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none

module wuns_nmi_enable_chk #(
    parameter int EVENTS = 12
) (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [wuns_pkg::ADDR_W-1:0] paddr,
    input wire logic [wuns_pkg::DATA_W-1:0] pwdata,
    input wire logic [wuns_pkg::DATA_W-1:0] prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [EVENTS-1:0]           watch_event,
    input wire logic [EVENTS-1:0]           nmi_enable,
    input wire logic                        nmi,
    input wire logic                        irq
);
    // ----
    // access decode
    // ----
    wire logic        acc    = psel && penable && pready;
    wire logic        at_set = paddr == wuns_pkg::OFS_NMI_ENABLE_SET;
    wire logic        at_clr = paddr == wuns_pkg::OFS_NMI_ENABLE_CLR;
    wire logic        wr_set = acc && pwrite && at_set;
    wire logic        wr_clr = acc && pwrite && at_clr;
    wire logic [11:0] wmap   = {pwdata[27:24], pwdata[7:0]};
    wire logic [31:0] rmap   = {4'h0, nmi_enable[11:8], 16'h0000, nmi_enable[7:0]};

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_set_ones: assert property (wr_set |=> (nmi_enable & $past(wmap)) == $past(wmap))
        else $error("set write did not raise its enables");
    a_set_keep: assert property (wr_set |=> (nmi_enable & ~$past(wmap)) == ($past(nmi_enable) & ~$past(wmap)))
        else $error("zero bits of a set write changed enables");
    a_clr_ones: assert property (wr_clr |=> (nmi_enable & $past(wmap)) == 12'h000)
        else $error("clear write did not drop its enables");
    a_set_read: assert property (acc && !pwrite && at_set |-> prdata == rmap)
        else $error("set register readback differs from enables");
    a_clr_read: assert property (acc && !pwrite && at_clr |-> prdata == rmap)
        else $error("clear register readback differs from enables");
    a_enable_cause: assert property (!$stable(nmi_enable) |-> $past(wr_set || wr_clr))
        else $error("enables changed without a set or clear write");

    c_set: cover property (wr_set && wmap != 12'h000);
    c_clr: cover property (wr_clr && wmap != 12'h000);
    c_nmi: cover property ($rose(nmi));
endmodule : wuns_nmi_enable_chk

`default_nettype wire

// >>> bench/wuns_nmi_enable_tb.sv
// testbench of the nmi enable block: apb tasks, enable set/clear, event to nmi/irq
// assumes the package and the checker are compiled first; one 10 MHz clock
`timescale 1ns/1ns
`default_nettype none

module wuns_nmi_enable_tb;
    localparam int         EVENTS = wuns_pkg::EVENT_COUNT;
    localparam logic [11:0] A_SET = wuns_pkg::OFS_NMI_ENABLE_SET;
    localparam logic [11:0] A_CLR = wuns_pkg::OFS_NMI_ENABLE_CLR;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [EVENTS-1:0] watch_event;
    logic [EVENTS-1:0] nmi_enable;
    logic              nmi;
    logic              irq;
    logic [31:0]       rd;
    logic              err;
    logic [11:0]       en;
    int                errors;
    int                samples_checked;

    wuns_nmi_enable #(.EVENTS(EVENTS)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .watch_event(watch_event), .nmi_enable(nmi_enable),
        .nmi(nmi), .irq(irq));

    always #50 pclk = ~pclk;

    // ----
    // tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // idle edge first, so psel is never assigned twice in one time step
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        check(32'(n == 16), 32'h0000_0000);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    function automatic logic [31:0] spread(input logic [11:0] e);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < 12; i++) w[wuns_pkg::FIELD_POS[i]] = e[i];
        return w;
    endfunction : spread

    task automatic pulse(input logic [11:0] ev);
        @(posedge pclk);
        watch_event <= ev;
        @(posedge pclk);
        watch_event <= 12'h000;
        repeat (2) @(posedge pclk);
    endtask : pulse

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // ----
    // sequence
    // ----
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        watch_event = 12'h000;
        errors = 0;
        samples_checked = 0;
        en = 12'h000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, A_SET, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0000);
        $display("test reset values done");
        // one field per write; earlier enables must survive the zeros
        for (int i = 0; i < 12; i++) begin
            en[i] = 1'b1;
            xfer(1'b1, A_SET, spread(12'h001 << i));
            xfer(1'b0, A_SET, 32'h0000_0000);
            check(rd, spread(en));
            check(32'(nmi_enable), 32'(en));
        end
        xfer(1'b1, A_SET, 32'hF0FF_FF00);
        xfer(1'b0, A_SET, 32'h0000_0000);
        check(rd, spread(en));
        $display("test set walk done");
        xfer(1'b1, A_CLR, spread(12'h5A5));
        en = 12'hA5A;
        xfer(1'b0, A_CLR, 32'h0000_0000);
        check(rd, spread(en));
        xfer(1'b0, A_SET, 32'h0000_0000);
        check(rd, spread(en));
        $display("test clear done");
        pulse(12'h008);
        check(32'(nmi), 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        // cause: valid flag on top, index 3 is the only pending enabled event
        xfer(1'b0, wuns_pkg::OFS_NMI_CAUSE, 32'h0000_0000);
        check(rd, 32'h8000_0003);
        check({31'h0000_0000, err}, 32'h0000_0000);
        xfer(1'b1, wuns_pkg::OFS_NMI_CAUSE, 32'hFFFF_FFFF);
        check({31'h0000_0000, err}, 32'h0000_0001);
        xfer(1'b1, wuns_pkg::OFS_IRQ_MASK, spread(12'h008));
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0000_0001);
        xfer(1'b1, wuns_pkg::OFS_EVENT_STATUS, spread(12'h008));
        xfer(1'b1, A_CLR, spread(12'h008));
        pulse(12'h008);
        check(32'(nmi), 32'h0000_0000);
        check(32'(irq), 32'h0000_0001);
        xfer(1'b1, wuns_pkg::OFS_EVENT_STATUS, spread(12'h008));
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0000_0000);
        $display("test events done");
        xfer(1'b0, 12'h0FC, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, A_SET, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(32'(nmi_enable), 32'h0000_0000);
        $display("test unmapped and reset done");
        final_report();
    end

    initial begin
        repeat (3000) @(posedge pclk);
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end
endmodule : wuns_nmi_enable_tb

bind wuns_nmi_enable wuns_nmi_enable_chk #(.EVENTS(EVENTS)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watch_event(watch_event), .nmi_enable(nmi_enable),
    .nmi(nmi), .irq(irq));

`default_nettype wire
